// >>> src/mul_div_sub_pkg.sv
// constants, types and register map of the signed multiply/divide/subtract unit
// assumes a single controller clock and word-addressed 16-bit data memory
package mul_div_sub_pkg;
   typedef enum logic [1:0] {OP_SUB, OP_MUL, OP_DIV} op_t;

   localparam int WORD_W = 16;
   localparam int DWORD_W = 32;
   localparam logic [3:0] OP_STEPS = 4'h7;

   localparam logic [15:0] ERR_RANGE = 16'h2003;
   localparam logic [15:0] ERR_DIV_ZERO = 16'h2012;
   localparam logic [15:0] ERR_NONE = 16'h0000;

   // register offsets on the register port
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CLEAR = 8'h04;
   localparam logic [7:0] REG_ENABLE = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0c;
   localparam logic [7:0] REG_ERROR_CODE = 8'h10;

   // status/clear/enable layout
   localparam int EV_DONE = 0;
   localparam int EV_ERROR = 1;
   localparam int EV_W = 2;
   // flags register layout
   localparam int FLAG_ZERO = 0;
   localparam int FLAG_BORROW = 1;
   localparam int FLAG_ERROR = 2;

   localparam logic [EV_W-1:0] ENABLE_RESET = 2'h0;
   localparam logic [15:0] ERROR_CODE_RESET = 16'h0000;
endpackage

// >>> src/signed_divider.sv
// signed restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/10ps
module signed_divider #(
   parameter int WIDTH = 32
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire logic [WIDTH-1:0] dividend,
   input wire logic [WIDTH-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [WIDTH-1:0] quotient,
   output logic [WIDTH-1:0] remainder
);
   localparam int CNT_W = $clog2(WIDTH + 1);

   generate
      if (WIDTH < 2) begin : g_check
         $error("divider width must be at least 2");
      end
   endgenerate

   function automatic logic [WIDTH-1:0] magnitude(input logic [WIDTH-1:0] v);
      magnitude = v[WIDTH-1] ? (~v + 1'b1) : v;
   endfunction

   logic [WIDTH:0] rem_ff;
   logic [WIDTH-1:0] quo_ff;
   logic [WIDTH-1:0] dsr_ff;
   logic [CNT_W-1:0] count_ff;
   logic quoNeg_ff;
   logic remNeg_ff;
   logic busy_ff;
   logic done_ff;
   logic [WIDTH-1:0] quotient_ff;
   logic [WIDTH-1:0] remainder_ff;

   wire [WIDTH:0] shifted = {rem_ff[WIDTH-1:0], quo_ff[WIDTH-1]};
   wire [WIDTH:0] trial = shifted - {1'b0, dsr_ff};
   wire fits = ~trial[WIDTH];
   wire [WIDTH:0] nxt_rem = fits ? trial : shifted;
   wire [WIDTH-1:0] nxt_quo = {quo_ff[WIDTH-2:0], fits};
   wire lastStep = busy_ff && (count_ff == CNT_W'(WIDTH - 1));
   // quotient truncates toward zero, remainder takes the dividend's sign
   wire [WIDTH-1:0] nxt_quotient = quoNeg_ff ? (~nxt_quo + 1'b1) : nxt_quo;
   wire [WIDTH-1:0] nxt_remainder = remNeg_ff ? (~nxt_rem[WIDTH-1:0] + 1'b1)
                                              : nxt_rem[WIDTH-1:0];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rem_ff <= '0;
         quo_ff <= '0;
         dsr_ff <= '0;
         count_ff <= '0;
         quoNeg_ff <= 1'b0;
         remNeg_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (start && !busy_ff) begin
         rem_ff <= '0;
         quo_ff <= magnitude(dividend);
         dsr_ff <= magnitude(divisor);
         count_ff <= '0;
         quoNeg_ff <= dividend[WIDTH-1] ^ divisor[WIDTH-1];
         remNeg_ff <= dividend[WIDTH-1];
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
      end else begin
         rem_ff <= busy_ff ? nxt_rem : rem_ff;
         quo_ff <= busy_ff ? nxt_quo : quo_ff;
         count_ff <= busy_ff ? count_ff + 1'b1 : count_ff;
         busy_ff <= busy_ff && !lastStep;
         done_ff <= lastStep;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         quotient_ff <= '0;
         remainder_ff <= '0;
      end else if (lastStep) begin
         quotient_ff <= nxt_quotient;
         remainder_ff <= nxt_remainder;
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
   assign quotient = quotient_ff;
   assign remainder = remainder_ff;
endmodule

// >>> src/signed_mul_div_sub_unit.sv
// arithmetic execution unit: binary subtract, signed multiply, signed divide
// assumes the sequencer gives one-cycle start pulses only while busy is low,
// and writes the result words it is handed into its data memory
// limitation: a start while busy is dropped with no sign, and the range check
// guards every operation, so a short device range refuses long results too
`timescale 1ns/10ps
module signed_mul_div_sub_unit #(
   parameter int ADDR_W = 16,
   parameter int DEV_WORDS = 65536
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire mul_div_sub_pkg::op_t opCode,
   input wire logic wideForm,
   input wire logic [31:0] operandA,
   input wire logic [31:0] operandB,
   input wire logic [ADDR_W-1:0] destBase,
   output logic busy,
   output logic resultValid,
   output logic [ADDR_W-1:0] resultAddr,
   output logic [2:0] resultWords,
   output logic [15:0] resultWord0,
   output logic [15:0] resultWord1,
   output logic [15:0] resultWord2,
   output logic [15:0] resultWord3,
   output logic [3:0] opSteps,
   output logic borrowFlag,
   output logic zeroFlag,
   output logic operationErrorFlag,
   output logic [15:0] errorCodeWord,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   output logic irq
);
   localparam int SPAN_W = ADDR_W + 2;

   generate
      if (ADDR_W < 1 || ADDR_W > 30 || DEV_WORDS < 4 || DEV_WORDS > (1 << ADDR_W)) begin : g_check
         $error("address width or device range not supported");
      end
   endgenerate

   typedef enum logic {ST_IDLE, ST_DIVIDE} state_t;

   // words written by each form: destination span used for the range check
   // a divide counts its quotient and its remainder words
   function automatic logic [2:0] wordsFor(input mul_div_sub_pkg::op_t op, input logic wide);
      logic [2:0] n;
      n = 3'h1;
      unique case (op)
         mul_div_sub_pkg::OP_SUB: n = wide ? 3'h2 : 3'h1;
         mul_div_sub_pkg::OP_MUL: n = wide ? 3'h4 : 3'h2;
         mul_div_sub_pkg::OP_DIV: n = wide ? 3'h4 : 3'h2;
         default: n = 3'h1;
      endcase
      return n;
   endfunction

   function automatic logic [31:0] signExtend(input logic [31:0] v, input logic wide);
      return wide ? v : {{16{v[15]}}, v[15:0]};
   endfunction

   // register decode is shared by the write side and the read side
   function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   // reset release through two flip-flops
   // so every register leaves reset on the same clock edge
   logic rstMeta_ff;
   logic rstSync_ff;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   state_t state_ff;
   logic [ADDR_W-1:0] resultAddr_ff;
   logic [2:0] resultWords_ff;
   logic [15:0] resultWord_ff [4];
   logic resultValid_ff;

   // flags and error state seen by software
   logic borrow_ff;
   logic zero_ff;
   logic error_ff;
   logic [15:0] errorCode_ff;

   // divide bookkeeping and register file
   logic divWide_ff;
   logic [mul_div_sub_pkg::EV_W-1:0] status_ff;
   logic [mul_div_sub_pkg::EV_W-1:0] enable_ff;
   logic [31:0] regRdata_ff;

   wire idle = (state_ff == ST_IDLE);
   wire take = start && idle;

   // operand conditioning
   wire [31:0] srcA = signExtend(operandA, wideForm);
   wire [31:0] srcB = signExtend(operandB, wideForm);
   wire [2:0] needWords = wordsFor(opCode, wideForm);
   // one past the last word written; the extra bits keep the sum from wrapping
   wire [SPAN_W-1:0] spanEnd = SPAN_W'(destBase) + SPAN_W'(needWords);
   wire rangeBad = spanEnd > SPAN_W'(DEV_WORDS);
   wire divZero = wideForm ? (operandB == 32'h0) : (operandB[15:0] == 16'h0);

   // subtraction at the operand width; the borrow is the carry out of the wrap
   wire [32:0] wideDiff = {1'b0, operandA} - {1'b0, operandB};
   // narrow form: the borrow is an unsigned compare of the low words
   wire [16:0] narrowDiff = {1'b0, operandA[15:0]} - {1'b0, operandB[15:0]};
   wire [31:0] subResult = wideForm ? wideDiff[31:0] : {16'h0, narrowDiff[15:0]};
   wire subBorrow = wideForm ? wideDiff[32] : narrowDiff[16];
   wire subZero = wideForm ? (wideDiff[31:0] == 32'h0) : (narrowDiff[15:0] == 16'h0);

   // signed product; a 16x16 product fits 32 bits so its sign lands in bit 31
   wire signed [63:0] product = $signed(srcA) * $signed(srcB);
   wire [63:0] prodBits = product;
   wire prodSign = wideForm ? prodBits[63] : prodBits[31];

   // divider runs on sign-extended operands for both forms
   wire divStart = take && (opCode == mul_div_sub_pkg::OP_DIV) && !rangeBad && !divZero;
   wire divDone;
   wire [31:0] divQuot;
   wire [31:0] divRem;

   // narrow divides reuse the wide divider, so both forms take the same time
   signed_divider #(
      .WIDTH(32)
   ) u_divider (
      .clock(clock),
      .resetn(rstSync_ff),
      .start(divStart),
      .dividend(srcA),
      .divisor(srcB),
      .busy(),
      .done(divDone),
      .quotient(divQuot),
      .remainder(divRem)
   );

   // errors abort before any result; range is checked ahead of the divisor
   wire failRange = take && rangeBad;
   wire failDivZero = take && !rangeBad && (opCode == mul_div_sub_pkg::OP_DIV) && divZero;
   wire failAny = failRange || failDivZero;
   wire finishFast = take && !rangeBad && (opCode != mul_div_sub_pkg::OP_DIV);
   wire finishDiv = (state_ff == ST_DIVIDE) && divDone;
   wire finishAny = finishFast || finishDiv;

   // result words, lower word at the lower address
   logic [15:0] nxt_word [4];
   logic [2:0] nxt_words;
   always_comb begin
      nxt_words = needWords;
      nxt_word[0] = subResult[15:0];
      nxt_word[1] = subResult[31:16];
      nxt_word[2] = 16'h0;
      nxt_word[3] = 16'h0;
      // a finishing divide owns the words; the operand ports may hold a new request
      if (finishDiv) begin
         nxt_words = divWide_ff ? 3'h4 : 3'h2;
         if (divWide_ff) begin
            nxt_word[0] = divQuot[15:0];
            nxt_word[1] = divQuot[31:16];
            nxt_word[2] = divRem[15:0];
            nxt_word[3] = divRem[31:16];
         end else begin
            nxt_word[0] = divQuot[15:0];
            nxt_word[1] = divRem[15:0];
         end
      end else if (opCode == mul_div_sub_pkg::OP_MUL) begin
         nxt_word[0] = prodBits[15:0];
         nxt_word[1] = prodBits[31:16];
         nxt_word[2] = wideForm ? prodBits[47:32] : 16'h0;
         nxt_word[3] = wideForm ? {prodSign, prodBits[62:48]} : 16'h0;
      end
   end

   always_ff @(posedge clock or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         state_ff <= ST_IDLE;
         divWide_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (divStart) begin
                  state_ff <= ST_DIVIDE;
                  divWide_ff <= wideForm;
               end
            end
            ST_DIVIDE: begin
               if (divDone) begin
                  state_ff <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // words and valid update at completion; the address updates at the take edge
   always_ff @(posedge clock or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         resultAddr_ff <= '0;
         resultWords_ff <= 3'h0;
         resultValid_ff <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            resultWord_ff[i] <= 16'h0;
         end
      end else begin
         resultValid_ff <= finishAny;
         // the address is caught at the take edge, since the sequencer
         // may move destBase while a divide runs
         if (take) begin
            resultAddr_ff <= destBase;
         end
         if (finishAny) begin
            resultWords_ff <= nxt_words;
            for (int i = 0; i < 4; i++) begin
               resultWord_ff[i] <= nxt_word[i];
            end
         end
      end
   end

   // register port decode
   // status is read-only: a write to its offset falls through every decode
   wire wrClear = regWrite && regHit(regAddr, mul_div_sub_pkg::REG_CLEAR);
   wire wrEnable = regWrite && regHit(regAddr, mul_div_sub_pkg::REG_ENABLE);
   wire wrFlags = regWrite && regHit(regAddr, mul_div_sub_pkg::REG_FLAGS);
   wire errClear = wrFlags && regWdata[mul_div_sub_pkg::FLAG_ERROR];
   wire [mul_div_sub_pkg::EV_W-1:0] events = {failAny, finishAny};
   wire [mul_div_sub_pkg::EV_W-1:0] clearBits =
      wrClear ? regWdata[mul_div_sub_pkg::EV_W-1:0] : '0;

   // subtraction flags change only with a completed subtraction
   always_ff @(posedge clock or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         borrow_ff <= 1'b0;
         zero_ff <= 1'b0;
      end else if (finishFast && (opCode == mul_div_sub_pkg::OP_SUB)) begin
         borrow_ff <= subBorrow;
         zero_ff <= subZero;
      end
   end

   // error flag is sticky; a new error wins over a clear in the same cycle
   always_ff @(posedge clock or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         error_ff <= 1'b0;
         errorCode_ff <= mul_div_sub_pkg::ERROR_CODE_RESET;
      end else begin
         error_ff <= failAny || (error_ff && !errClear);
         // range wins over a zero divisor when both are wrong
         if (failRange) begin
            errorCode_ff <= mul_div_sub_pkg::ERR_RANGE;
         end else if (failDivZero) begin
            errorCode_ff <= mul_div_sub_pkg::ERR_DIV_ZERO;
         end
      end
   end

   always_ff @(posedge clock or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         status_ff <= '0;
         enable_ff <= mul_div_sub_pkg::ENABLE_RESET;
      end else begin
         // set wins over clear, so an event in the clearing cycle is not lost
         status_ff <= events | (status_ff & ~clearBits);
         if (wrEnable) begin
            enable_ff <= regWdata[mul_div_sub_pkg::EV_W-1:0];
         end
      end
   end

   wire [31:0] flagsWord = {29'h0, error_ff, borrow_ff, zero_ff};
   wire [31:0] readMux =
      regHit(regAddr, mul_div_sub_pkg::REG_STATUS) ? {30'h0, status_ff} :
      regHit(regAddr, mul_div_sub_pkg::REG_ENABLE) ? {30'h0, enable_ff} :
      regHit(regAddr, mul_div_sub_pkg::REG_FLAGS) ? flagsWord :
      regHit(regAddr, mul_div_sub_pkg::REG_ERROR_CODE) ? {16'h0, errorCode_ff} :
      32'h0;

   // read data stand only in the cycle after the strobe
   // a quiet zero between reads lets the sequencer merge several ports
   always_ff @(posedge clock or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         regRdata_ff <= 32'h0;
      end else begin
         regRdata_ff <= regRead ? readMux : 32'h0;
      end
   end

   // operation side
   assign busy = !idle;
   assign resultValid = resultValid_ff;
   assign resultAddr = resultAddr_ff;
   assign resultWords = resultWords_ff;
   assign resultWord0 = resultWord_ff[0];
   assign resultWord1 = resultWord_ff[1];
   assign resultWord2 = resultWord_ff[2];
   assign resultWord3 = resultWord_ff[3];

   // fixed program length of every multiply and divide form
   assign opSteps = mul_div_sub_pkg::OP_STEPS;

   // flags and error reporting
   assign borrowFlag = borrow_ff;
   assign zeroFlag = zero_ff;
   assign operationErrorFlag = error_ff;
   assign errorCodeWord = errorCode_ff;

   // register port and interrupt
   assign regRdata = regRdata_ff;
   assign irq = |(status_ff & enable_ff);
endmodule

// >>> tb/seq_memory.sv
// sequencer-side data memory: stores every word of a completed result
// assumes no more than four words per result and a small device range
`timescale 1ns/10ps
module seq_memory #(
   parameter int DEV_WORDS = 64
) (
   input wire logic clock,
   input wire logic resultValid,
   input wire logic [15:0] resultAddr,
   input wire logic [2:0] resultWords,
   input wire logic [15:0] resultWord0,
   input wire logic [15:0] resultWord1,
   input wire logic [15:0] resultWord2,
   input wire logic [15:0] resultWord3
);
   logic [15:0] mem [0:DEV_WORDS+3];
   logic [63:0] all;
   assign all = {resultWord3, resultWord2, resultWord1, resultWord0};
   // all words land at one edge, low half at the lower address
   always @(posedge clock) begin
      if (resultValid === 1'b1) begin
         for (int i = 0; i < 4; i++) begin
            if (i < resultWords) mem[resultAddr+i] <= all[16*i +: 16];
         end
      end
   end
endmodule

// >>> tb/signed_mul_div_sub_unit_properties.sv
// timing and value properties of the multiply/divide/subtract unit
// assumes requests only after the internal reset release
`timescale 1ns/10ps
module signed_mul_div_sub_unit_properties #(
   parameter int ADDR_W = 16,
   parameter int DEV_WORDS = 65536
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire mul_div_sub_pkg::op_t opCode,
   input wire logic wideForm,
   input wire logic [31:0] operandA,
   input wire logic [31:0] operandB,
   input wire logic [ADDR_W-1:0] destBase,
   input wire logic busy,
   input wire logic resultValid,
   input wire logic [ADDR_W-1:0] resultAddr,
   input wire logic [15:0] resultWord0,
   input wire logic [15:0] resultWord1,
   input wire logic [15:0] resultWord2,
   input wire logic [15:0] resultWord3,
   input wire logic [3:0] opSteps,
   input wire logic borrowFlag,
   input wire logic zeroFlag,
   input wire logic operationErrorFlag,
   input wire logic [15:0] errorCodeWord
);
   logic take, fits, dz, bor, zr, isSub, isDiv;
   logic [2:0] nW;
   logic [32:0] diff;
   logic [31:0] subRes;
   logic [63:0] mulRes;
   assign isSub = opCode == mul_div_sub_pkg::OP_SUB;
   assign isDiv = opCode == mul_div_sub_pkg::OP_DIV;
   assign take = start && !busy;
   assign nW = isSub ? (wideForm ? 3'h2 : 3'h1) : (wideForm ? 3'h4 : 3'h2);
   assign fits = (32'(destBase) + 32'(nW)) <= DEV_WORDS;
   assign dz = wideForm ? operandB == 32'h0 : operandB[15:0] == 16'h0;
   assign diff = wideForm ? {1'b0, operandA} - {1'b0, operandB}
      : {17'h0, operandA[15:0]} - {17'h0, operandB[15:0]};
   assign bor = wideForm ? diff[32] : diff[16];
   assign subRes = wideForm ? diff[31:0] : {16'h0, diff[15:0]};
   assign zr = subRes == 32'h0;
   // sign-extended unsigned multiply keeps the low bits of a signed product exact
   assign mulRes = wideForm ? {{32{operandA[31]}}, operandA} * {{32{operandB[31]}}, operandB}
      : {32'h0, {{16{operandA[15]}}, operandA[15:0]} * {{16{operandB[15]}}, operandB[15:0]}};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   a_steps_fixed: assert property (opSteps == 4'h7)
      else $error("step count is not seven");
   a_sub_flags: assert property (take && fits && isSub |=>
      borrowFlag == $past(bor) && zeroFlag == $past(zr)) else $error("subtract flags wrong");
   a_sub_words: assert property (take && fits && isSub |=>
      {resultWord1, resultWord0} == $past(subRes)) else $error("difference words wrong");
   a_mul_product: assert property (take && fits && opCode == mul_div_sub_pkg::OP_MUL |=>
      {resultWord3, resultWord2, resultWord1, resultWord0} == $past(mulRes))
      else $error("product words wrong");
   a_fast_done: assert property (take && fits && !isDiv |=>
      resultValid && resultAddr == $past(destBase)) else $error("result not delivered");
   a_div_timing: assert property (take && fits && isDiv && !dz |=>
      busy ##33 (resultValid && !busy)) else $error("divide result late or missing");
   a_div_zero: assert property (take && fits && isDiv && dz |=>
      operationErrorFlag && errorCodeWord == 16'h2012 && !resultValid)
      else $error("zero divisor not refused");
   a_range_err: assert property (take && !fits |=>
      operationErrorFlag && errorCodeWord == 16'h2003 && !resultValid)
      else $error("range error not raised");
endmodule
bind signed_mul_div_sub_unit signed_mul_div_sub_unit_properties #(.ADDR_W(ADDR_W),
   .DEV_WORDS(DEV_WORDS)) signed_mul_div_sub_unit_properties_i (.clock(clock), .resetn(resetn),
   .start(start), .opCode(opCode), .wideForm(wideForm), .operandA(operandA),
   .operandB(operandB), .destBase(destBase), .busy(busy), .resultValid(resultValid),
   .resultAddr(resultAddr), .resultWord0(resultWord0), .resultWord1(resultWord1),
   .resultWord2(resultWord2), .resultWord3(resultWord3), .opSteps(opSteps),
   .borrowFlag(borrowFlag), .zeroFlag(zeroFlag), .operationErrorFlag(operationErrorFlag),
   .errorCodeWord(errorCodeWord));

// >>> tb/signed_mul_div_sub_unit_tb.sv
// self-checking bench of the multiply/divide/subtract unit
// assumes a device range of 64 words so range errors are reachable
`timescale 1ns/10ps
module signed_mul_div_sub_unit_tb;
   logic clock, resetn, start, wideForm, busy, resultValid, borrowFlag, zeroFlag;
   logic operationErrorFlag, regWrite, regRead, irq, rdLate;
   mul_div_sub_pkg::op_t opCode;
   logic [31:0] operandA, operandB, regWdata, regRdata;
   logic [15:0] destBase, resultAddr, resultWord0, resultWord1, resultWord2, resultWord3;
   logic [15:0] errorCodeWord;
   logic [2:0] resultWords;
   logic [3:0] opSteps;
   logic [7:0] regAddr;
   logic [1:0] expBz;
   logic [84:0] expQ[$];
   logic [31:0] rdQ[$];
   int n_mismatch, n_tests, seed;
   signed_mul_div_sub_unit #(.DEV_WORDS(64)) signed_mul_div_sub_unit_i (.*);
   seq_memory #(.DEV_WORDS(64)) seq_memory_i (.*);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic bad(input string m);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [84:0] g, input logic [84:0] e);
      n_tests++;
      if (g !== e) bad($sformatf("got %h want %h", g, e));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
   endtask
   // operands are plain words here, so a loop counter bit can pick the narrow form through w
   task automatic op(input mul_div_sub_pkg::op_t o, input logic w, input logic [31:0] a,
      input logic [31:0] b, input logic [15:0] d);
      logic [63:0] r;
      logic [32:0] s;
      logic [2:0] n;
      logic [15:0] code;
      logic signed [31:0] sa, sb;
      logic signed [15:0] ha, hb;
      sa = a;
      sb = b;
      ha = a[15:0];
      hb = b[15:0];
      s = w ? {1'b0, a} - {1'b0, b} : {17'h0, a[15:0]} - {17'h0, b[15:0]};
      n = (o == mul_div_sub_pkg::OP_SUB) ? (w ? 3'h2 : 3'h1) : (w ? 3'h4 : 3'h2);
      code = (32'(d) + 32'(n) > 32'd64) ? 16'h2003 : (o == mul_div_sub_pkg::OP_DIV
         && (w ? b : {16'h0, b[15:0]}) == 32'h0) ? 16'h2012 : 16'h0;
      case (o)
         mul_div_sub_pkg::OP_SUB: begin
            r = w ? {32'h0, s[31:0]} : {48'h0, s[15:0]};
            if (code == 16'h0) expBz = {w ? s[32] : s[16], r == 64'h0};
         end
         mul_div_sub_pkg::OP_MUL: r = w ? {{32{a[31]}}, a} * {{32{b[31]}}, b}
            : {32'h0, {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]}};
         default: r = w ? {sa % sb, sa / sb} : {32'h0, ha % hb, ha / hb};
      endcase
      if (code == 16'h0) expQ.push_back({d, n, r, expBz});
      opCode <= o;
      wideForm <= w;
      operandA <= a;
      operandB <= b;
      destBase <= d;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      #1;
      if (code != 16'h0) begin
         chk({68'h0, operationErrorFlag, errorCodeWord}, {68'h0, 1'b1, code});
      end else if (o == mul_div_sub_pkg::OP_DIV) begin
         // a second request while dividing must vanish without a result
         start <= 1'b1;
         @(posedge clock);
         start <= 1'b0;
         repeat (40) if (busy === 1'b1) begin
            @(posedge clock);
            #1;
         end
         if (busy !== 1'b0) bad("divide did not finish");
      end
   endtask
   wire [84:0] got = {resultAddr, resultWords, resultWord3, resultWord2, resultWord1,
      resultWord0, borrowFlag, zeroFlag};
   always @(posedge clock) rdLate <= regRead;
   always @(negedge clock) begin
      if (resultValid === 1'b1) begin
         if (expQ.size() == 0) bad("result with nothing pending");
         else chk(got, expQ.pop_front());
      end
      if (rdLate === 1'b1) chk({53'h0, regRdata}, {53'h0, rdQ.pop_front()});
   end
   // about 350 cycles are needed; the margin covers a stuck divide
   initial begin
      #50000;
      bad("watchdog expired");
      final_report();
   end
   initial begin
      {resetn, start, wideForm, regWrite, regRead, operandA, operandB} = '0;
      {destBase, regAddr, regWdata, expBz, n_mismatch, n_tests} = '0;
      opCode = mul_div_sub_pkg::OP_SUB;
      seed = 53;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      rd(8'h00, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      chk({81'h0, opSteps}, {81'h0, 4'h7});
      $display("test reset values done");
      op(mul_div_sub_pkg::OP_SUB, 1'b1, 32'h8000_0000, 32'hffff_ffff, 16'h10);
      op(mul_div_sub_pkg::OP_SUB, 1'b1, 32'd111111111, 32'd55555555, 16'h12);
      op(mul_div_sub_pkg::OP_SUB, 1'b1, 32'h1234_5678, 32'h1234_5678, 16'h14);
      op(mul_div_sub_pkg::OP_SUB, 1'b0, 32'h0000_0001, 32'h0000_0002, 16'h16);
      op(mul_div_sub_pkg::OP_SUB, 1'b0, 32'h0000_0000, 32'h0000_ffff, 16'h3f);
      $display("test subtract done");
      op(mul_div_sub_pkg::OP_MUL, 1'b1, 32'hffff_fffe, 32'h0000_0003, 16'h20);
      op(mul_div_sub_pkg::OP_MUL, 1'b0, 32'h0000_ffff, 32'h0000_0002, 16'h24);
      op(mul_div_sub_pkg::OP_MUL, 1'b1, 32'h8000_0000, 32'h8000_0000, 16'h3c);
      for (int i = 0; i < 8; i++) begin
         op(mul_div_sub_pkg::OP_MUL, i[0], $random(seed), $random(seed), 16'(i * 4));
      end
      $display("test multiply done");
      for (int i = 0; i < 8; i++) begin
         op(mul_div_sub_pkg::OP_DIV, i[2], i[0] ? -32'sd7 : 32'sd7, i[1] ? -32'sd2 : 32'sd2,
            16'h30);
      end
      op(mul_div_sub_pkg::OP_DIV, 1'b1, $random(seed), $random(seed) | 32'h1, 16'h30);
      $display("test divide done");
      chk({69'h0, seq_memory_i.mem[16'h23]}, {69'h0, 16'hffff});
      rd(8'h00, 32'h1);
      wr(8'h08, 32'h1);
      chk({84'h0, irq}, {84'h0, 1'b1});
      wr(8'h08, 32'h0);
      chk({84'h0, irq}, {84'h0, 1'b0});
      wr(8'h04, 32'h1);
      rd(8'h00, 32'h0);
      op(mul_div_sub_pkg::OP_DIV, 1'b0, 32'h5, 32'h0001_0000, 16'h30);
      op(mul_div_sub_pkg::OP_MUL, 1'b1, 32'h5, 32'h3, 16'h3d);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h2);
      wr(8'h08, 32'h2);
      chk({84'h0, irq}, {84'h0, 1'b1});
      rd(8'h10, 32'h2003);
      rd(8'h0c, {29'h0, 1'b1, expBz[1], expBz[0]});
      wr(8'h0c, 32'h4);
      chk({84'h0, operationErrorFlag}, 85'h0);
      wr(8'h04, 32'h3);
      chk({84'h0, irq}, {84'h0, 1'b0});
      $display("test errors and interrupt done");
      repeat (3) @(posedge clock);
      final_report();
   end
endmodule
